// [hwl_load_unit.sv]
// half-word load datapath: address generation, alignment check, writeback
// assumes data memory answers one cycle after a read strobe
`timescale 1ns/100ps
module hwl_load_unit import hwl_pkg::*; (
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic issueValid,
	input hwl_instr_t issueInstr,
	output logic issueReady,
	output logic [31:0] memAddr,
	output logic memRead,
	input wire logic [15:0] memData,
	input wire logic dbgWrEn,
	input wire logic [1:0] dbgRegSel,
	input wire logic [3:0] dbgIdx,
	input wire logic [31:0] dbgWrData,
	output logic [31:0] dbgRdData,
	output hwl_status_t status
);
	hwl_state_t state_ff, nxt_state;
	hwl_instr_t ins_ff, nxt_ins;
	logic [31:0] addr_ff, nxt_addr;
	logic [31:0] ptrNew_ff, nxt_ptrNew;
	logic ptrUpd_ff, nxt_ptrUpd;
	hwl_status_t status_ff, nxt_status;

	logic [NUM_DREG*32-1:0] dAll;
	logic [NUM_PREG*32-1:0] pAll;
	logic [NUM_IREG*32-1:0] iAll;
	logic dWe, pWe, iWe;
	logic [2:0] dIdx, pIdx;
	logic [1:0] iIdx;
	logic [31:0] dWd, pWd, iWd;
	logic [31:0] dRd, pRd, iRd;

	logic [31:0] baseVal, stepVal, effAddr, oldDest, mergedData;
	logic [31:0] offVal;
	logic misalign, badIssue;

	hwl_regfile #(.NREG(NUM_DREG), .AW(3)) uData (
		.mclk(mclk), .arst_n(arst_n), .wrEn(dWe), .wrIdx(dIdx),
		.wrData(dWd), .rdIdx(dbgIdx[2:0]), .rdData(dRd), .allRegs(dAll)
	);
	hwl_regfile #(.NREG(NUM_PREG), .AW(3)) uPtr (
		.mclk(mclk), .arst_n(arst_n), .wrEn(pWe), .wrIdx(pIdx),
		.wrData(pWd), .rdIdx(dbgIdx[2:0]), .rdData(pRd), .allRegs(pAll)
	);
	hwl_regfile #(.NREG(NUM_IREG), .AW(2)) uIdx (
		.mclk(mclk), .arst_n(arst_n), .wrEn(iWe), .wrIdx(iIdx),
		.wrData(iWd), .rdIdx(dbgIdx[1:0]), .rdData(iRd),
		.allRegs(iAll)
	);

	// address and post-modify value for the incoming instruction
	always_comb begin
		// the sign suffix is not an input at all: it cannot alter anything
		baseVal = pAll[issueInstr.ptrA*32 +: 32];
		if (issueInstr.useIndex) begin
			baseVal = iAll[{1'b0, issueInstr.ireg}*32 +: 32];
		end
		offVal = 32'h0000_0000;
		stepVal = baseVal;
		nxt_ptrUpd = 1'b0;
		case (issueInstr.amode)
			HWL_POSTINC: begin
				stepVal = baseVal + HALF_STEP;
				nxt_ptrUpd = 1'b1;
			end
			HWL_POSTDEC: begin
				stepVal = baseVal - HALF_STEP;
				nxt_ptrUpd = 1'b1;
			end
			HWL_SHORTOFF: begin
				// offset field counts half-words, so scale by two
				offVal = {26'h0, issueInstr.offset[SHORT_OFF_W-1:0], 1'b0};
			end
			HWL_LONGADD: begin
				offVal = {15'h0, issueInstr.offset, 1'b0};
			end
			HWL_LONGSUB: begin
				offVal = 32'h0000_0000 - {15'h0, issueInstr.offset, 1'b0};
			end
			HWL_INDEXED: begin
				stepVal = baseVal + pAll[issueInstr.ptrB*32 +: 32];
				nxt_ptrUpd = (issueInstr.ptrA != issueInstr.ptrB);
			end
			default: begin
				stepVal = baseVal;
			end
		endcase
		effAddr = baseVal + offVal;
		misalign = effAddr[0];
		// long encodings in parallel, encoding length not matching the mode, and partial loads with long shape are refused
		badIssue = (issueInstr.longEnc && issueInstr.parallel)
			|| (issueInstr.longEnc != (issueInstr.amode == HWL_LONGADD
			|| issueInstr.amode == HWL_LONGSUB))
			|| (issueInstr.dest != HWL_SIGNED && issueInstr.longEnc);
	end

	always_comb begin
		nxt_state = state_ff;
		nxt_ins = ins_ff;
		nxt_addr = addr_ff;
		nxt_ptrNew = ptrNew_ff;
		nxt_status = '0;
		case (state_ff)
			HWL_IDLE: begin
				// a request under a debug write is not taken
				if (issueValid && issueReady) begin
					nxt_ins = issueInstr;
					nxt_addr = effAddr;
					nxt_ptrNew = stepVal;
					if (badIssue) begin
						nxt_status.illegalIssue = 1'b1;
					end else if (misalign) begin
						nxt_status.exc = 1'b1;
					end else begin
						nxt_state = HWL_WAIT;
					end
				end
			end
			HWL_WAIT: nxt_state = HWL_DONE;
			HWL_DONE: begin
				nxt_status.done = 1'b1;
				nxt_state = HWL_IDLE;
			end
			default: nxt_state = HWL_IDLE;
		endcase
	end

	// writeback in the done state; nothing is written on an exception
	always_comb begin
		oldDest = dAll[ins_ff.dreg*32 +: 32];
		case (ins_ff.dest)
			HWL_UPPER: mergedData = {memData, oldDest[15:0]};
			HWL_LOWER: mergedData = {oldDest[31:16], memData};
			default: mergedData = hwl_sext(memData);
		endcase
		dWe = (state_ff == HWL_DONE) || (dbgWrEn && dbgRegSel == 2'h0);
		dIdx = (state_ff == HWL_DONE) ? ins_ff.dreg : dbgIdx[2:0];
		dWd = (state_ff == HWL_DONE) ? mergedData : dbgWrData;
		pWe = (state_ff == HWL_DONE && ptrUpd_ff && !ins_ff.useIndex)
			|| (dbgWrEn && dbgRegSel == 2'h1);
		pIdx = (state_ff == HWL_DONE) ? ins_ff.ptrA : dbgIdx[2:0];
		pWd = (state_ff == HWL_DONE) ? ptrNew_ff : dbgWrData;
		iWe = (state_ff == HWL_DONE && ptrUpd_ff && ins_ff.useIndex)
			|| (dbgWrEn && dbgRegSel == 2'h2);
		iIdx = (state_ff == HWL_DONE) ? ins_ff.ireg : dbgIdx[1:0];
		iWd = (state_ff == HWL_DONE) ? ptrNew_ff : dbgWrData;
	end

	logic ptrUpdHold;
	always_comb begin
		ptrUpdHold = ptrUpd_ff;
		if (issueValid && issueReady) begin
			ptrUpdHold = nxt_ptrUpd;
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			state_ff <= HWL_IDLE;
			ins_ff <= '0;
			addr_ff <= REG_RST;
			ptrNew_ff <= REG_RST;
			ptrUpd_ff <= 1'b0;
			status_ff <= '0;
		end else begin
			state_ff <= nxt_state;
			ins_ff <= nxt_ins;
			addr_ff <= nxt_addr;
			ptrNew_ff <= nxt_ptrNew;
			ptrUpd_ff <= ptrUpdHold;
			status_ff <= nxt_status;
		end
	end

	assign issueReady = (state_ff == HWL_IDLE) && !dbgWrEn;
	assign memAddr = addr_ff;
	assign memRead = (state_ff == HWL_WAIT);
	assign status = status_ff;
	always_comb begin
		case (dbgRegSel)
			2'h1: dbgRdData = pRd;
			2'h2: dbgRdData = iRd;
			default: dbgRdData = dRd;
		endcase
	end
endmodule

// [hwl_pkg.sv]
// package for the half-word load datapath: constants, kinds, carriers
// assumes one core clock; instruction decode happens upstream
// Overview of operation
// - sign load copies bit 15 upward
// - odd effective address raises misaligned exception
// - post-modify uses old pointer, then +/-2
// - short form: pointer plus even 6-bit offset
// - long form: pointer plus/minus 17-bit even offset
// - sign suffix changes nothing at all
// - register-indexed form adds second pointer after load
// - same pointer twice: plain load, no update
// - long encodings never issue in parallel
// - upper-half load writes bits 31:16 only
// - lower-half load writes bits 15:0 only
// - partial loads take index or pointer source
// - partial load forms are 16-bit encodings
// - eight data, four index, eight pointer registers
// - long offset forms use 32-bit encoding
package hwl_pkg;
	localparam int DATA_W = 32;
	localparam int HALF_W = 16;
	localparam int NUM_DREG = 8;
	localparam int NUM_PREG = 8;
	localparam int NUM_IREG = 4;
	localparam int STACK_PTR_IDX = 6;
	localparam int FRAME_PTR_IDX = 7;
	localparam logic [31:0] HALF_STEP = 32'h0000_0002;
	localparam logic [31:0] REG_RST = 32'h0000_0000;
	localparam int SHORT_OFF_W = 5;
	localparam int LONG_OFF_W = 16;
	localparam int MEM_LAT = 1;

	typedef enum logic [2:0] {
		HWL_PLAIN = 3'h0,
		HWL_POSTINC = 3'h1,
		HWL_POSTDEC = 3'h2,
		HWL_SHORTOFF = 3'h3,
		HWL_LONGADD = 3'h4,
		HWL_LONGSUB = 3'h5,
		HWL_INDEXED = 3'h6
	} hwl_amode_t;

	typedef enum logic [1:0] {
		HWL_SIGNED = 2'h0,
		HWL_UPPER = 2'h1,
		HWL_LOWER = 2'h2
	} hwl_dest_t;

	typedef enum logic [1:0] {
		HWL_IDLE = 2'b00,
		HWL_WAIT = 2'b01,
		HWL_DONE = 2'b11
	} hwl_state_t;

	typedef struct packed {
		hwl_dest_t dest;
		hwl_amode_t amode;
		logic useIndex;
		logic [2:0] dreg;
		logic [2:0] ptrA;
		logic [2:0] ptrB;
		logic [1:0] ireg;
		logic [15:0] offset;
		logic longEnc;
		logic parallel;
	} hwl_instr_t;

	typedef struct packed {
		logic exc;
		logic illegalIssue;
		logic done;
	} hwl_status_t;

	function automatic logic [31:0] hwl_sext(input logic [15:0] h);
		hwl_sext = {{16{h[15]}}, h};
	endfunction
endpackage

// [hwl_regfile.sv]
// register storage for data, pointer and index registers
// assumes writes come from the main datapath on the same clock
`timescale 1ns/100ps
module hwl_regfile import hwl_pkg::*; #(
	parameter int NREG = 8,
	parameter int AW = 3
) (
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic wrEn,
	input wire logic [AW-1:0] wrIdx,
	input wire logic [31:0] wrData,
	input wire logic [AW-1:0] rdIdx,
	output logic [31:0] rdData,
	output logic [NREG*32-1:0] allRegs
);
	logic [31:0] mem_ff [NREG];
	logic [31:0] nxt_mem [NREG];
	logic [31:0] rdData_ff;

	always_comb begin
		for (int i = 0; i < NREG; i++) begin
			nxt_mem[i] = mem_ff[i];
		end
		if (wrEn) begin
			nxt_mem[wrIdx] = wrData;
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			for (int i = 0; i < NREG; i++) begin
				mem_ff[i] <= REG_RST;
			end
			rdData_ff <= REG_RST;
		end else begin
			for (int i = 0; i < NREG; i++) begin
				mem_ff[i] <= nxt_mem[i];
			end
			rdData_ff <= mem_ff[rdIdx];
		end
	end

	always_comb begin
		for (int i = 0; i < NREG; i++) begin
			allRegs[i*32 +: 32] = mem_ff[i];
		end
	end

	assign rdData = rdData_ff;
endmodule

// [hwl_mem_model.sv]
// data memory seen by the half-word load unit
// assumes a read strobe of one cycle; data follows one cycle later
`timescale 1ns/100ps
module hwl_mem_model (
	input wire logic mclk,
	input wire logic memRead,
	input wire logic [31:0] memAddr,
	output logic [15:0] memData
);
	logic [15:0] word_ff = 16'h0000;
	assign memData = word_ff;
	// word tracks the address so a wrong address shows as wrong data
	// outside the one answer cycle the bus flips, so stale data cannot pass
	always @(posedge mclk) begin
		if (memRead)
			word_ff <= memAddr[15:0] + 16'h7F00;
		else
			word_ff <= ~word_ff;
	end
endmodule

// [hwl_load_properties.sv]
// checker of the half-word load unit: issue, strobe and status timing
// assumes a bind to hwl_load_unit, single clock domain
`timescale 1ns/100ps
module hwl_load_props import hwl_pkg::*; (
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic issueValid,
	input hwl_instr_t issueInstr,
	input wire logic issueReady,
	input wire logic [31:0] memAddr,
	input wire logic memRead,
	input hwl_status_t status
);
	logic take;
	logic isLong;
	assign take = issueValid && issueReady;
	assign isLong = issueInstr.amode inside {HWL_LONGADD, HWL_LONGSUB};
	default clocking @(posedge mclk); endclocking
	default disable iff (!arst_n);
	sequence s_ok;
		!status.exc && !status.illegalIssue;
	endsequence
	sequence s_walk;
		memRead && !issueReady ##1 !issueReady ##1 status.done;
	endsequence
	a_load_walk: assert property (take ##1 s_ok |-> s_walk)
		else $error("load did not complete in three cycles");
	a_exc_quiet: assert property (take ##1 status.exc |=> !status.done [*3])
		else $error("done after misaligned access");
	a_read_once: assert property (memRead |=> !memRead)
		else $error("read strobe longer than one cycle");
	a_addr_hold: assert property (memRead |=> $stable(memAddr) [*2])
		else $error("address moved during access");
	a_par_refuse: assert property (
		take && issueInstr.longEnc && issueInstr.parallel |=> status.illegalIssue)
		else $error("long form accepted in parallel");
	a_part_long: assert property (
		take && issueInstr.longEnc && issueInstr.dest != HWL_SIGNED
		|=> status.illegalIssue)
		else $error("partial load accepted as long form");
	a_long_mode: assert property (
		take && issueInstr.longEnc != isLong |=> status.illegalIssue)
		else $error("encoding length does not match mode");
	a_short_ok: assert property (
		take && !issueInstr.longEnc && !isLong |=> !status.illegalIssue)
		else $error("short form refused");
	a_addr_even: assert property (memRead |-> !memAddr[0])
		else $error("odd address reached memory");
	a_exc_no_read: assert property (
		take ##1 status.exc |-> !memRead)
		else $error("memory read after misaligned access");
	a_bad_no_read: assert property (
		take ##1 status.illegalIssue |-> !memRead)
		else $error("memory read after refused issue");
endmodule
bind hwl_load_unit hwl_load_props u_props (.mclk(mclk), .arst_n(arst_n),
	.issueValid(issueValid), .issueInstr(issueInstr),
	.issueReady(issueReady), .memAddr(memAddr), .memRead(memRead),
	.status(status));

// [hwl_load_unit_tb.sv]
// testbench of the half-word load unit: table of loads, then refusals
// assumes the memory model answers address plus 7F00 one cycle later
`timescale 1ns/100ps
module hwl_load_unit_tb import hwl_pkg::*; ;
	typedef struct {hwl_dest_t d; hwl_amode_t m; logic u;
		logic [2:0] pa, pb; logic [15:0] o; logic [19:0] ea, ep;} hwl_row_t;
	typedef struct {hwl_dest_t d; hwl_amode_t m; logic l, p;} hwl_bad_t;
	logic mclk = 1'b0, arst_n = 1'b0, issueValid = 1'b0, dbgWrEn = 1'b0;
	hwl_instr_t issueInstr = '0;
	logic [1:0] dbgRegSel = 2'h0;
	logic [3:0] dbgIdx = 4'h0;
	logic [31:0] dbgWrData = 32'h0, dbgRdData, memAddr, ad, v;
	logic [15:0] memData;
	logic issueReady, memRead;
	hwl_status_t status;
	int n_mismatch = 0, comparisons = 0;
	// pointers distinct for indexing except one same-pointer row, short offsets at most 30 bytes
	hwl_row_t rows[12] = '{
		'{HWL_SIGNED, HWL_PLAIN, 1'h0, 3'h0, 3'h1, 16'h0, 20'h100, 20'h100},
		'{HWL_SIGNED, HWL_POSTINC, 1'h0, 3'h0, 3'h1, 16'h0, 20'h100, 20'h102},
		'{HWL_SIGNED, HWL_POSTDEC, 1'h0, 3'h6, 3'h1, 16'h0, 20'h100, 20'hFE},
		'{HWL_SIGNED, HWL_SHORTOFF, 1'h0, 3'h7, 3'h1, 16'hF, 20'h11E, 20'h100},
		'{HWL_SIGNED, HWL_LONGADD, 1'h0, 3'h0, 3'h1, 16'hFFFF, 20'h200FE, 20'h100},
		'{HWL_SIGNED, HWL_LONGSUB, 1'h0, 3'h0, 3'h1, 16'h80, 20'h0, 20'h100},
		'{HWL_SIGNED, HWL_INDEXED, 1'h0, 3'h0, 3'h1, 16'h0, 20'h100, 20'h106},
		'{HWL_SIGNED, HWL_INDEXED, 1'h0, 3'h0, 3'h0, 16'h0, 20'h100, 20'h100},
		'{HWL_UPPER, HWL_PLAIN, 1'h1, 3'h0, 3'h1, 16'h0, 20'h100, 20'h100},
		'{HWL_LOWER, HWL_POSTINC, 1'h1, 3'h0, 3'h1, 16'h0, 20'h100, 20'h102},
		'{HWL_UPPER, HWL_POSTDEC, 1'h1, 3'h0, 3'h1, 16'h0, 20'h100, 20'hFE},
		'{HWL_LOWER, HWL_INDEXED, 1'h0, 3'h0, 3'h1, 16'h0, 20'h100, 20'h106}};
	hwl_bad_t bad[5] = '{'{HWL_SIGNED, HWL_POSTINC, 1'h0, 1'h0},
		'{HWL_SIGNED, HWL_LONGADD, 1'h1, 1'h1}, '{HWL_UPPER, HWL_PLAIN, 1'h1, 1'h0},
		'{HWL_SIGNED, HWL_SHORTOFF, 1'h1, 1'h0}, '{HWL_SIGNED, HWL_PLAIN, 1'h0, 1'h1}};
	always #12.5 mclk = ~mclk;
	hwl_load_unit dut (.mclk(mclk), .arst_n(arst_n), .issueValid(issueValid),
		.issueInstr(issueInstr), .issueReady(issueReady), .memAddr(memAddr),
		.memRead(memRead), .memData(memData), .dbgWrEn(dbgWrEn),
		.dbgRegSel(dbgRegSel), .dbgIdx(dbgIdx), .dbgWrData(dbgWrData),
		.dbgRdData(dbgRdData), .status(status));
	hwl_mem_model mem (.mclk(mclk), .memRead(memRead), .memAddr(memAddr),
		.memData(memData));
	task automatic conclude();
		$display("comparisons=%0d mismatches=%0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		comparisons++;
		if (g !== e) begin
			n_mismatch++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [1:0] s, input logic [3:0] i,
		input logic [31:0] d);
		@(negedge mclk);
		dbgWrEn = 1'b1;
		dbgRegSel = s;
		dbgIdx = i;
		dbgWrData = d;
		@(negedge mclk);
		dbgWrEn = 1'b0;
	endtask
	task automatic rd(input logic [1:0] s, input logic [3:0] i,
		output logic [31:0] d);
		@(negedge mclk);
		dbgRegSel = s;
		dbgIdx = i;
		@(negedge mclk);
		d = dbgRdData;
	endtask
	// waits bounded: a load that never reports ends the run
	task automatic ld(input hwl_instr_t x, output hwl_status_t st);
		@(negedge mclk);
		issueInstr = x;
		issueValid = 1'b1;
		@(negedge mclk);
		issueValid = 1'b0;
		st = '0;
		for (int k = 0; k < 8 && st === '0; k++) begin
			if (memRead)
				ad = memAddr;
			st = status;
			@(negedge mclk);
		end
		if (st === '0) begin
			n_mismatch++;
			conclude();
		end
	endtask
	initial begin
		hwl_row_t w;
		hwl_instr_t x;
		hwl_status_t st;
		logic [15:0] h;
		repeat (12) @(negedge mclk);
		arst_n = 1'b1;
		rd(2'h0, 4'h0, v);
		chk(v, REG_RST);
		$display("reset test done");
		foreach (rows[r]) begin
			w = rows[r];
			wr(2'h1, {1'h0, w.pa}, 32'h100);
			wr(2'h1, 4'h1, 32'h6);
			wr(2'h2, 4'h0, 32'h100);
			wr(2'h0, 4'h0, 32'h12345678);
			x = '{w.d, w.m, w.u, 3'h0, w.pa, w.pb, 2'h0, w.o,
				w.m inside {HWL_LONGADD, HWL_LONGSUB}, 1'h0};
			ld(x, st);
			chk(ad, {12'h0, w.ea});
			chk({29'h0, st}, 32'h1);
			rd(w.u ? 2'h2 : 2'h1, {1'h0, w.pa}, v);
			chk(v, {12'h0, w.ep});
			rd(2'h0, 4'h0, v);
			h = w.ea[15:0] + 16'h7F00;
			chk(v, w.d == HWL_UPPER ? {h, 16'h5678} : w.d == HWL_LOWER ?
				{16'h1234, h} : {{16{h[15]}}, h});
			$display("row %0d done", r);
		end
		foreach (bad[b]) begin
			wr(2'h1, 4'h0, b == 0 ? 32'h101 : 32'h100);
			wr(2'h0, 4'h0, 32'h12345678);
			x = '{bad[b].d, bad[b].m, 1'h0, 3'h0, 3'h0, 3'h1, 2'h0, 16'h0,
				bad[b].l, bad[b].p};
			ld(x, st);
			chk({29'h0, st}, b == 0 ? 32'h4 : b == 4 ? 32'h1 : 32'h2);
			rd(2'h1, 4'h0, v);
			chk(v, b == 0 ? 32'h101 : 32'h100);
			rd(2'h0, 4'h0, v);
			chk(v, b == 4 ? 32'hFFFF8000 : 32'h12345678);
			$display("refusal %0d done", b);
		end
		// reset in mid-run: registers hold nonzero values before it
		@(negedge mclk);
		arst_n = 1'b0;
		@(negedge mclk);
		arst_n = 1'b1;
		rd(2'h1, 4'h0, v);
		chk(v, REG_RST);
		rd(2'h0, 4'h0, v);
		chk(v, REG_RST);
		$display("mid-run reset test done");
		conclude();
	end
endmodule
